/* rtl/ttto_top.sv */
// Thermal throttle pin block: input timer with limit alert, fan override, and critical-limit output.
// Notes on behaviour
// - Limit zero raises the alert at the first throttle input assertion.
// - Limit one alerts past 45.52 ms accumulated; each step scales the threshold.
// - Config 3 bit 1 enables timer monitoring; clear after reset.
// - Config 4 pin-function field selects the pin; throttle needs timer enable.
// - Full_speed_on_throttle_bit bit drives running fans at full duty while the pin is asserted.
// - Fans not already running are not raised to full speed.
// - Mask 2 bit 5 suppresses the alert when the pin function is throttle; mask 1 bit 0 does otherwise.
// - Output pulls pin low when a temperature exceeds its critical limit.
// - Output stays low until a later measurement is at or below the limit.
// - Three critical limits: remote one, local, remote two, consecutive addresses.
// - Config 5 bits 7:5 enable output for remote two, local, remote one.
// - Critical limit at the format floor disables that channel's output.
// - Config 7 bit 0 disables output hysteresis.
// - Throttle-disable bit blocks the pin only while hysteresis is enabled.
// - In manual mode throttle reaches fans only with config 6 bit 3 set.
// - Config 4 bit 3 chooses full duty or programmed maximum duty.
// - Config 4 bit 2 stops throttle events changing fan drive.
// - Fan drive offers several low PWM frequencies and one high one.
// - Timer accumulates across assertions, clears on read, saturates at full scale.
// - Bit 0 sets on first assertion; later 22.76 ms per count.
// - Timer above limit sets status bit 5 and raises alert unless masked.
`include "ttto_defs.svh"
module ttto_top import ttto_pkg::*; #(
    parameter int unsigned TICK_CYC  = `TTTO_TICK_CYC,
    parameter int unsigned CYCLE_CYC = `TTTO_CYCLE_DEF
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        thermal_throttle_pin_in,
    output logic             thermal_throttle_pin_out,
    output logic             thermal_throttle_pin_oe,
    input  wire logic        fourth_speed_input_in,
    input  wire logic [7:0]  temp_remote1,
    input  wire logic [7:0]  temp_local,
    input  wire logic [7:0]  temp_remote2,
    input  wire logic [2:0]  fan_running,
    input  wire logic        manual_mode,
    output logic             smbus_alert_n,
    output logic [2:0]       fan_force_full,
    output logic [2:0]       fan_force_max,
    output logic [1:0]       pwm_freq_sel,
    output logic             pwm_high_freq
);
    typedef struct packed {
        ttto_bus_st_t bus;
        logic [31:0]  rdata;
        logic [7:0]   cfg3;
        logic [7:0]   cfg4;
        logic [7:0]   cfg5;
        logic [7:0]   cfg6;
        logic [7:0]   cfg7;
        logic [7:0]   mask1;
        logic [7:0]   mask2;
        logic [7:0]   istat2;
        logic [7:0]   limit;
        logic [7:0]   timer;
        logic [7:0]   crit_r1;
        logic [7:0]   crit_loc;
        logic [7:0]   crit_r2;
        logic [7:0]   fanctl;
        logic         twos;
        logic [31:0]  tick_cnt;
        logic [31:0]  cyc_cnt;
        logic         sample;
        logic         was_asserted;
        logic [2:0]   full_speed_on_throttle_bit_lock;
        logic         alert_n;
        logic         pin_oe;
        logic [2:0]   force_full;
        logic [2:0]   force_max;
        logic         step1;
        logic         waitreq;
    } ttto_state_t;

    ttto_state_t st_r;
    ttto_state_t st_nxt;
    logic [2:0]  trip;
    logic        throt_sel;
    logic        in_on;
    logic        in_assert;
    logic        fan_ok;
    logic        over;
    logic        hit;

    // Per-channel critical comparators: bit 0 remote one, bit 1 local, bit 2 remote two.
    ttto_chan u_ch_r1 (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .sample   (st_r.sample),
        .temp     (temp_remote1),
        .crit     (st_r.crit_r1),
        .enable   (st_r.cfg5[`TTTO_CFG5_EN_LSB]),
        .twos_fmt (st_r.twos),
        .no_hyst  (st_r.cfg7[`TTTO_BIT_NOHYST]),
        .trip     (trip[0])
    );
    ttto_chan u_ch_loc (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .sample   (st_r.sample),
        .temp     (temp_local),
        .crit     (st_r.crit_loc),
        .enable   (st_r.cfg5[`TTTO_CFG5_EN_LSB + 1]),
        .twos_fmt (st_r.twos),
        .no_hyst  (st_r.cfg7[`TTTO_BIT_NOHYST]),
        .trip     (trip[1])
    );
    ttto_chan u_ch_r2 (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .sample   (st_r.sample),
        .temp     (temp_remote2),
        .crit     (st_r.crit_r2),
        .enable   (st_r.cfg5[`TTTO_CFG5_EN_LSB + 2]),
        .twos_fmt (st_r.twos),
        .no_hyst  (st_r.cfg7[`TTTO_BIT_NOHYST]),
        .trip     (trip[2])
    );

    // Selects the throttle input source and decides whether the alert and fan paths are live.
    always_comb begin
        throt_sel = (st_r.cfg4[1:0] == `TTTO_PINF_THROT);
        in_on     = st_r.cfg3[`TTTO_BIT_TMR_EN];
        in_assert = in_on && (!thermal_throttle_pin_in || (throt_sel && !fourth_speed_input_in));
        fan_ok    = !st_r.cfg4[`TTTO_BIT_NOFAN] && (!manual_mode || st_r.cfg6[`TTTO_BIT_MANTHR]);
        over      = (st_r.timer > st_r.limit);
        hit       = (st_r.limit == 8'h00) && in_assert;
    end

    // Next-state logic for bus, timer, flags and outputs.
    always_comb begin
        st_nxt = st_r;
        st_nxt.sample = 1'b0;
        // Monitoring cycle strobe for the channel comparators.
        if (st_r.cyc_cnt >= CYCLE_CYC - 1) begin
            st_nxt.cyc_cnt = '0;
            st_nxt.sample  = 1'b1;
        end else begin
            st_nxt.cyc_cnt = st_r.cyc_cnt + 32'h0000_0001;
        end
        // Timer accumulates assertion time and saturates at full scale.
        if (in_assert) begin
            if (!st_r.was_asserted && st_r.timer == 8'h00) begin
                st_nxt.timer = 8'h01;
            end
            if (st_r.tick_cnt >= TICK_CYC - 1) begin
                st_nxt.tick_cnt = '0;
                st_nxt.step1    = 1'b1;
                if (st_r.step1 && st_r.timer != 8'hff) begin
                    st_nxt.timer = st_r.timer + 8'h01;
                end
            end else begin
                st_nxt.tick_cnt = st_r.tick_cnt + 32'h0000_0001;
            end
        end
        st_nxt.was_asserted = in_assert;
        // Avalon slave: one wait cycle, answer in the next.
        case (st_r.bus)
            TTTO_IDLE: begin
                if (avs_read || avs_write) begin
                    st_nxt.bus = TTTO_WAIT;
                end
                // Read data is taken early so that it stands at the answer edge.
                if (avs_read) begin
                    st_nxt.rdata = '0;
                    if (avs_address == `TTTO_OFF_CFG3) begin
                        st_nxt.rdata = {24'h0, st_r.cfg3};
                    end else if (avs_address == `TTTO_OFF_CFG4) begin
                        st_nxt.rdata = {24'h0, st_r.cfg4};
                    end else if (avs_address == `TTTO_OFF_CFG5) begin
                        st_nxt.rdata = {24'h0, st_r.cfg5};
                    end else if (avs_address == `TTTO_OFF_CFG6) begin
                        st_nxt.rdata = {24'h0, st_r.cfg6};
                    end else if (avs_address == `TTTO_OFF_CFG7) begin
                        st_nxt.rdata = {24'h0, st_r.cfg7};
                    end else if (avs_address == `TTTO_OFF_IMASK1) begin
                        st_nxt.rdata = {24'h0, st_r.mask1};
                    end else if (avs_address == `TTTO_OFF_IMASK2) begin
                        st_nxt.rdata = {24'h0, st_r.mask2};
                    end else if (avs_address == `TTTO_OFF_LIMIT) begin
                        st_nxt.rdata = {24'h0, st_r.limit};
                    end else if (avs_address == `TTTO_OFF_CRIT_R1) begin
                        st_nxt.rdata = {24'h0, st_r.crit_r1};
                    end else if (avs_address == `TTTO_OFF_CRIT_LOC) begin
                        st_nxt.rdata = {24'h0, st_r.crit_loc};
                    end else if (avs_address == `TTTO_OFF_CRIT_R2) begin
                        st_nxt.rdata = {24'h0, st_r.crit_r2};
                    end else if (avs_address == `TTTO_OFF_TEMPS) begin
                        st_nxt.rdata = {31'h0, st_r.twos};
                    end else if (avs_address == `TTTO_OFF_FANCTL) begin
                        st_nxt.rdata = {24'h0, st_r.fanctl};
                    end else if (avs_address == `TTTO_OFF_STATUS) begin
                        st_nxt.rdata = {24'h0, st_r.pin_oe, trip, st_r.force_full, in_assert};
                    end else if (avs_address == `TTTO_OFF_ISTAT2) begin
                        st_nxt.rdata = {24'h0, st_r.istat2};
                    end else if (avs_address == `TTTO_OFF_TIMER) begin
                        st_nxt.rdata = {24'h0, st_r.timer};
                    end
                end
            end
            TTTO_WAIT: begin
                st_nxt.bus = TTTO_DONE;
                if (avs_write) begin
                    if (avs_address == `TTTO_OFF_CFG3) begin
                        st_nxt.cfg3 = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_CFG4) begin
                        st_nxt.cfg4 = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_CFG5) begin
                        st_nxt.cfg5 = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_CFG6) begin
                        st_nxt.cfg6 = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_CFG7) begin
                        st_nxt.cfg7 = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_IMASK1) begin
                        st_nxt.mask1 = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_IMASK2) begin
                        st_nxt.mask2 = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_LIMIT) begin
                        st_nxt.limit = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_CRIT_R1) begin
                        st_nxt.crit_r1 = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_CRIT_LOC) begin
                        st_nxt.crit_loc = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_CRIT_R2) begin
                        st_nxt.crit_r2 = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_TEMPS) begin
                        st_nxt.twos = avs_writedata[0];
                    end else if (avs_address == `TTTO_OFF_FANCTL) begin
                        st_nxt.fanctl = avs_writedata[7:0];
                    end else if (avs_address == `TTTO_OFF_ISTAT2) begin
                        st_nxt.istat2 = st_r.istat2 & ~avs_writedata[7:0];
                    end
                end else if (avs_address == `TTTO_OFF_TIMER) begin
                    st_nxt.tick_cnt = '0;
                    st_nxt.step1    = 1'b0;
                    st_nxt.timer    = in_assert ? 8'h01 : 8'h00;
                end
            end
            TTTO_DONE: begin
                st_nxt.bus = TTTO_IDLE;
            end
            default: begin
                st_nxt.bus = TTTO_IDLE;
            end
        endcase
        st_nxt.waitreq = (st_nxt.bus != TTTO_WAIT);
        // Status flag: hardware set wins over a software clear in the same cycle.
        if (over || hit) begin
            st_nxt.istat2[`TTTO_BIT_TMR_FLAG] = 1'b1;
        end
        st_nxt.alert_n = !(st_r.istat2[`TTTO_BIT_TMR_FLAG]
                           && !(throt_sel ? st_r.mask2[`TTTO_BIT_MASK2] : st_r.mask1[`TTTO_BIT_MASK1]));
        // Fan override only for fans that were running when the assertion began.
        if (!in_assert) begin
            st_nxt.full_speed_on_throttle_bit_lock = '0;
        end else if (!st_r.was_asserted) begin
            st_nxt.full_speed_on_throttle_bit_lock = fan_running;
        end
        if (in_assert && st_r.cfg3[`TTTO_BIT_FULL_SPEED_ON_THROTTLE_BIT] && fan_ok) begin
            st_nxt.force_full = st_r.cfg4[`TTTO_BIT_USEMAX] ? 3'h0 : st_nxt.full_speed_on_throttle_bit_lock;
            st_nxt.force_max  = st_r.cfg4[`TTTO_BIT_USEMAX] ? st_nxt.full_speed_on_throttle_bit_lock : 3'h0;
        end else begin
            st_nxt.force_full = 3'h0;
            st_nxt.force_max  = 3'h0;
        end
        // Pin drive: throttle-disable bit only blocks while hysteresis is on.
        st_nxt.pin_oe = (|trip) && in_on
                        && !(st_r.cfg4[`TTTO_BIT_NOFAN] && !st_r.cfg7[`TTTO_BIT_NOHYST]);
    end

    // State register.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_r          <= '0;
            st_r.bus      <= TTTO_IDLE;
            st_r.alert_n  <= 1'b1;
            st_r.waitreq  <= 1'b1;
            st_r.crit_r1  <= `TTTO_CRIT_RESET;
            st_r.crit_loc <= `TTTO_CRIT_RESET;
            st_r.crit_r2  <= `TTTO_CRIT_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops; the pin data output is tied low.
    assign avs_readdata             = st_r.rdata;
    assign avs_waitrequest          = st_r.waitreq;
    assign thermal_throttle_pin_out = 1'b0;
    assign thermal_throttle_pin_oe  = st_r.pin_oe;
    assign smbus_alert_n            = st_r.alert_n;
    assign fan_force_full           = st_r.force_full;
    assign fan_force_max            = st_r.force_max;
    assign pwm_freq_sel             = st_r.fanctl[1:0];
    assign pwm_high_freq            = st_r.fanctl[2];
endmodule : ttto_top

/* include/ttto_defs.svh */
// Offsets, field positions, reset values and timing figures of the thermal throttle block.
`ifndef TTTO_DEFS_SVH
`define TTTO_DEFS_SVH
`define TTTO_OFF_CFG7      8'h11
`define TTTO_OFF_CFG6      8'h10
`define TTTO_OFF_ISTAT2    8'h42
`define TTTO_OFF_CRIT_R1   8'h6a
`define TTTO_OFF_CRIT_LOC  8'h6b
`define TTTO_OFF_CRIT_R2   8'h6c
`define TTTO_OFF_IMASK1    8'h74
`define TTTO_OFF_IMASK2    8'h75
`define TTTO_OFF_CFG3      8'h78
`define TTTO_OFF_TIMER     8'h79
`define TTTO_OFF_LIMIT     8'h7a
`define TTTO_OFF_CFG5      8'h7c
`define TTTO_OFF_CFG4      8'h7d
`define TTTO_OFF_TEMPS     8'h80
`define TTTO_OFF_FANCTL    8'h81
`define TTTO_OFF_STATUS    8'h82
`define TTTO_BIT_TMR_EN    1
`define TTTO_BIT_FULL_SPEED_ON_THROTTLE_BIT     2
`define TTTO_BIT_NOFAN     2
`define TTTO_BIT_USEMAX    3
`define TTTO_BIT_MANTHR    3
`define TTTO_BIT_NOHYST    0
`define TTTO_BIT_TMR_FLAG  5
`define TTTO_BIT_MASK1     0
`define TTTO_BIT_MASK2     5
`define TTTO_CFG5_EN_LSB   5
`define TTTO_PINF_THROT    2'h1
`define TTTO_CRIT_RESET    8'h64
`define TTTO_OFF64_FLOOR   8'h00
`define TTTO_TWOS_FLOOR    8'h80
`define TTTO_TICK_US       22760
`define TTTO_CLK_MHZ       100
`define TTTO_TICK_CYC      (`TTTO_TICK_US * `TTTO_CLK_MHZ / 1000 * 1000)
`define TTTO_CYCLE_DEF     1000000
`endif

/* include/ttto_pkg.sv */
// Types shared by the thermal throttle block.
package ttto_pkg;
    typedef enum logic [2:0] {
        TTTO_IDLE  = 3'b001,
        TTTO_WAIT  = 3'b010,
        TTTO_DONE  = 3'b100
    } ttto_bus_st_t;
endpackage : ttto_pkg

/* rtl/ttto_chan.sv */
// One temperature channel's over-limit comparator and throttle request with hysteresis.
`include "ttto_defs.svh"
module ttto_chan import ttto_pkg::*; (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       sample,
    input  wire logic [7:0] temp,
    input  wire logic [7:0] crit,
    input  wire logic       enable,
    input  wire logic       twos_fmt,
    input  wire logic       no_hyst,
    output logic            trip
);
    typedef struct packed {
        logic trip;
    } ttto_chan_st_t;
    ttto_chan_st_t st_r;
    ttto_chan_st_t st_nxt;
    logic signed [9:0] t_v;
    logic signed [9:0] c_v;
    logic              dis;

    // Compare in a common signed range; quarter-degree excess is any value above limit.
    always_comb begin
        st_nxt = st_r;
        t_v = twos_fmt ? {{2{temp[7]}}, temp} : {2'b00, temp};
        c_v = twos_fmt ? {{2{crit[7]}}, crit} : {2'b00, crit};
        dis = twos_fmt ? (crit == `TTTO_TWOS_FLOOR) : (crit == `TTTO_OFF64_FLOOR);
        if (!enable || dis) begin
            st_nxt.trip = 1'b0;
        end else if (sample) begin
            if (t_v > c_v) begin
                st_nxt.trip = 1'b1;
            end else if (no_hyst || t_v <= c_v) begin
                st_nxt.trip = 1'b0;
            end
        end
    end

    // Trip changes on a new measurement, or clears at once when disabled, so it holds one full cycle unless disabled.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign trip = st_r.trip;
endmodule : ttto_chan

/* tb/ttto_top_assertions.sv */
// Concurrent checks on the ports of the thermal throttle block, bound into its top module.
module ttto_top_chk #(
    parameter int unsigned CYCLE_CYC = 16
) (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        thermal_throttle_pin_oe,
    input wire logic [2:0]  fan_running,
    input wire logic        smbus_alert_n,
    input wire logic [2:0]  fan_force_full,
    input wire logic [2:0]  fan_force_max,
    input wire logic [1:0]  pwm_freq_sel,
    input wire logic        pwm_high_freq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] oe_cnt_r;
    logic [2:0]  pwm_w_r;
    // Counts how long the pin is pulled and keeps the last fan control word taken.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            oe_cnt_r <= 32'h0;
            pwm_w_r  <= 3'h0;
        end else begin
            oe_cnt_r <= thermal_throttle_pin_oe ? oe_cnt_r + 32'h1 : 32'h0;
            if (avs_write && !avs_waitrequest && avs_address == 8'h81) begin
                pwm_w_r <= avs_writedata[2:0];
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wait_one_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    answer_soon_a: assert property ($rose(avs_read || avs_write) |-> ##[1:3] !avs_waitrequest)
        else $error("bus request not answered in time");
    wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without a request");
    rdata_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    force_excl_a: assert property ((fan_force_full & fan_force_max) == 3'h0)
        else $error("full and maximum duty requested together");
    force_running_a: assert property ($stable(fan_running)
        |-> ((fan_force_full | fan_force_max) & ~fan_running) == 3'h0)
        else $error("idle fan forced up");
    oe_hold_a: assert property ($fell(thermal_throttle_pin_oe) |-> oe_cnt_r >= CYCLE_CYC - 1)
        else $error("pin released before one monitoring cycle");
    pwm_follow_a: assert property (avs_write && !avs_waitrequest && avs_address == 8'h81
        |-> ##[1:3] {pwm_high_freq, pwm_freq_sel} == pwm_w_r)
        else $error("frequency select does not follow fan control write");
    read_seen_c: cover property (avs_read && !avs_waitrequest);
    alert_seen_c: cover property ($fell(smbus_alert_n));
    pin_seen_c: cover property ($rose(thermal_throttle_pin_oe));
endmodule : ttto_top_chk

bind ttto_top ttto_top_chk #(.CYCLE_CYC(CYCLE_CYC)) u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .thermal_throttle_pin_oe(thermal_throttle_pin_oe),
    .fan_running(fan_running), .smbus_alert_n(smbus_alert_n), .fan_force_full(fan_force_full),
    .fan_force_max(fan_force_max), .pwm_freq_sel(pwm_freq_sel), .pwm_high_freq(pwm_high_freq));

/* tb/ttto_hot_model.sv */
// Far-side driver of the open-drain throttle line, answering promptly or three edges late.
module ttto_hot_model (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic hot_req,
    input  wire logic slow,
    output logic      hot_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] dly_r;
    // The line has a pull-up, so a released line always reads high in the bench.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dly_r  <= 3'h0;
            hot_oe <= 1'b0;
        end else begin
            dly_r  <= {dly_r[1:0], hot_req};
            hot_oe <= slow ? dly_r[2] : hot_req;
        end
    end
endmodule : ttto_hot_model

/* tb/tb_top.sv */
// Self-checking bench for the thermal throttle block.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CY = 16;
    logic        clk_sys = 1'b0;
    logic        reset_n, avs_read, avs_write, avs_waitrequest, pin_out, pin_oe, pin_w;
    logic        hot_req, hot_slow, hot_oe, fourth_in, manual_mode, smbus_alert_n, pwm_hi;
    logic [7:0]  avs_address, c, w;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0]  tmp [3];
    logic [2:0]  fan_running, force_full, force_max;
    logic [1:0]  pwm_sel;
    logic [7:0]  exq [$];
    int          errors = 0;
    int          n_checks = 0;
    // Fan cases: cfg3, cfg4, cfg6, then {manual, 0, full, max}.
    logic [31:0] fan_tab [6] = '{32'h06000028,
                                 32'h02000000,
                                 32'h06080005,
                                 32'h06040000,
                                 32'h06000080,
                                 32'h060008a8};
    // The line is pulled up and low while either party pulls it.
    assign pin_w = (pin_oe ? pin_out : 1'b1) & ~hot_oe;
    always #5 clk_sys = ~clk_sys;
    ttto_top #(.TICK_CYC(20), .CYCLE_CYC(CY)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .thermal_throttle_pin_in(pin_w), .thermal_throttle_pin_out(pin_out),
        .thermal_throttle_pin_oe(pin_oe), .fourth_speed_input_in(fourth_in), .temp_remote1(tmp[0]),
        .temp_local(tmp[1]), .temp_remote2(tmp[2]), .fan_running(fan_running), .manual_mode(manual_mode),
        .smbus_alert_n(smbus_alert_n), .fan_force_full(force_full), .fan_force_max(force_max),
        .pwm_freq_sel(pwm_sel), .pwm_high_freq(pwm_hi));
    ttto_hot_model u_hot (.clk_sys(clk_sys), .reset_n(reset_n), .hot_req(hot_req), .slow(hot_slow),
        .hot_oe(hot_oe));
    task automatic report_and_stop();
        if (errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One Avalon transfer; a read notes its expected byte for the monitor.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk_sys);
        if (!wr) exq.push_back(d);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= {24'h0, d};
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 20) errors++;
        if (k == 20) report_and_stop();
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : bus
    // Far side pulls the line for n cycles, at a random answer speed.
    task automatic hot(input int n);
        hot_slow <= 1'($urandom_range(1, 0));
        hot_req  <= 1'b1;
        repeat (n) @(posedge clk_sys);
        hot_req  <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask : hot
    // Compares every read answer with the oldest noted expectation.
    always @(posedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk("readdata", exq.pop_front(), avs_readdata[7:0]);
    end
    // Cuts a hung run short.
    initial begin
        repeat (30000) @(posedge clk_sys);
        errors++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        {reset_n, avs_read, avs_write, hot_req, hot_slow, manual_mode} = 6'h0;
        {avs_address, avs_writedata, fan_running, fourth_in} = 44'h1;
        tmp = '{8'h0, 8'h0, 8'h0};
        void'($urandom(55030));
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 3; i++) bus(0, 8'(8'h6a + i), 8'h64);
        bus(0, 8'h78, 8'h00);
        bus(0, 8'h33, 8'h00);
        hot(40);
        chk("alert", 1, smbus_alert_n);
        bus(0, 8'h79, 8'h00);
        bus(1, 8'h78, 8'h02);
        bus(1, 8'h7a, 8'h00);
        hot(5);
        chk("alert", 0, smbus_alert_n);
        bus(0, 8'h42, 8'h20);
        bus(1, 8'h74, 8'h01);
        chk("alert", 1, smbus_alert_n);
        bus(1, 8'h74, 8'h00);
        chk("alert", 0, smbus_alert_n);
        bus(0, 8'h79, 8'h01);
        bus(1, 8'h42, 8'h20);
        chk("alert", 1, smbus_alert_n);
        bus(1, 8'h7a, 8'h01);
        hot(30);
        chk("alert", 1, smbus_alert_n);
        hot(20);
        chk("alert", 0, smbus_alert_n);
        bus(0, 8'h79, 8'h02);
        hot(55);
        hot(55);
        bus(0, 8'h79, 8'h05);
        bus(0, 8'h79, 8'h00);
        hot(5200);
        bus(0, 8'h79, 8'hff);
        bus(1, 8'h42, 8'h20);
        bus(1, 8'h7a, 8'h00);
        bus(1, 8'h7d, 8'h01);
        fourth_in <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("alert", 0, smbus_alert_n);
        bus(1, 8'h75, 8'h20);
        chk("alert", 1, smbus_alert_n);
        bus(1, 8'h7a, 8'hff);
        fourth_in <= 1'b1;
        fan_running <= 3'b101;
        foreach (fan_tab[i]) begin
            bus(1, 8'h78, fan_tab[i][31:24]);
            bus(1, 8'h7d, fan_tab[i][23:16]);
            bus(1, 8'h10, fan_tab[i][15:8]);
            manual_mode <= fan_tab[i][7];
            hot_req <= 1'b1;
            repeat (8) @(posedge clk_sys);
            chk("force_full", fan_tab[i][5:3], force_full);
            chk("force_max", fan_tab[i][2:0], force_max);
            hot_req <= 1'b0;
            repeat (8) @(posedge clk_sys);
        end
        manual_mode <= 1'b0;
        w = 8'($urandom_range(7, 0));
        bus(1, 8'h81, w);
        chk("pwm", w, {5'h0, pwm_hi, pwm_sel});
        for (int i = 0; i < 3; i++) begin
            c = 8'($urandom_range(8'h70, 8'h20));
            bus(1, 8'(8'h6a + i), c);
            tmp[i] <= c + 8'h1;
            bus(1, 8'h7c, 8'he0 & ~8'(8'h20 << i));
            repeat (3 * CY) @(posedge clk_sys);
            chk("pin_oe", 0, pin_oe);
            bus(1, 8'h7c, 8'(8'h20 << i));
            repeat (3 * CY) @(posedge clk_sys);
            chk("pin_oe", 1, pin_oe);
            tmp[i] <= c;
            repeat (3 * CY) @(posedge clk_sys);
            chk("pin_oe", 0, pin_oe);
        end
        bus(1, 8'h7c, 8'h20);
        bus(1, 8'h6a, 8'h00);
        tmp[0] <= 8'h10;
        repeat (3 * CY) @(posedge clk_sys);
        chk("pin_oe", 0, pin_oe);
        bus(1, 8'h6a, 8'h80);
        bus(1, 8'h80, 8'h01);
        repeat (3 * CY) @(posedge clk_sys);
        chk("pin_oe", 0, pin_oe);
        bus(1, 8'h80, 8'h00);
        bus(1, 8'h6a, 8'h40);
        bus(1, 8'h7d, 8'h04);
        tmp[0] <= 8'h41;
        repeat (3 * CY) @(posedge clk_sys);
        chk("pin_oe", 0, pin_oe);
        bus(1, 8'h11, 8'h01);
        repeat (3 * CY) @(posedge clk_sys);
        chk("pin_oe", 1, pin_oe);
        chk("pin_out", 0, pin_out);
        report_and_stop();
    end
endmodule : tb_top
